// ---- hdl/fcd_host.sv ----
`include "fcd_map.svh"
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  fcd_bus_if.host          bus
);
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  fcd_host_state_type state_r;
  logic [3:0]  tap_r;
  logic [2:0]  dec_r;
  logic        byp_r;
  logic [26:0] coef_r;
  logic [5:0]  n_coef_r;
  logic [5:0]  cnt_r;
  logic [15:0] sum_r;
  logic [31:0] gain_r;
  logic [15:0] wait_r;
  logic        verified_r;
  logic        gain_err_r;
  logic [`FCD_IRQ_W-1:0] irq_stat_r;
  logic [`FCD_IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic        wr_r;
  logic [15:0] wd_r;
  logic        rd_r;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc       = psel && penable;
  wire sel_ctrl  = paddr == `FCD_REG_CTRL;
  wire sel_coef  = paddr == `FCD_REG_COEF;
  wire sel_stat  = paddr == `FCD_REG_STAT;
  wire sel_irq   = paddr == `FCD_REG_IRQ;
  wire sel_mask  = paddr == `FCD_REG_MASK;
  wire mapped    = sel_ctrl || sel_coef || sel_stat || sel_irq || sel_mask;
  wire idle      = state_r == H_IDLE;
  wire loading   = state_r >= H_ADDR1 && state_r <= H_LO;
  // coefficient write stalls until the sequencer can take it
  wire coef_hold = sel_coef && pwrite && loading && state_r != H_WAITC;
  wire coef_bad  = sel_coef && pwrite && !loading;
  assign pready  = !coef_hold;
  assign pslverr = acc && (!mapped || coef_bad);
  wire done      = acc && pready;
  wire go_wr     = done && pwrite && sel_ctrl && pwdata[`FCD_GO_BIT] && idle;
  // only 6..48 taps in steps of 6
  wire code_ok   = pwdata[0];
  wire coef_wr   = done && pwrite && sel_coef && state_r == H_WAITC;
  wire irq_rd    = done && !pwrite && sel_irq;
  wire resp      = state_r == H_RESP && bus.rd_valid;
  wire sum_ok    = gain_r == `FCD_UNITY_SUM;
  wire [5:0]  n_req = 6'((pwdata[3:1] + 3'h1) * `FCD_TAP_STEP);
  wire [31:0] stat_w = {26'h0, gain_err_r, verified_r, 1'b0, loading,
                        !idle, idle};
  wire [31:0] rd_mux = sel_ctrl ? {24'h0, byp_r, dec_r, tap_r}
                     : sel_stat ? stat_w
                     : sel_irq  ? {29'h0, irq_stat_r}
                     : sel_mask ? {29'h0, irq_mask_r}
                     : 32'h0;

  // ----------------------------------------
  // words sent on the device port
  // ----------------------------------------
  // control word with load request
  wire [15:0] ctrl_ld = {1'b1, 6'h00, tap_r, byp_r, 1'b1, dec_r};
  // status readback select, same length and rate
  wire [15:0] ctrl_rd = {4'h0, 1'b1, 2'b00, tap_r, byp_r, 1'b1, dec_r};
  // padded upper word: zeros, sign, mag 25..16
  wire [15:0] hi_w    = {5'h00, coef_r[26:16]};
  wire [15:0] lo_w    = coef_r[15:0];
  wire send = state_r == H_ADDR1 || state_r == H_CTRL1 || state_r == H_HI
              || state_r == H_LO || state_r == H_SUM || state_r == H_ADDR2
              || state_r == H_CTRL2;
  // address words carry the control address
  wire [15:0] word_sel = (state_r == H_CTRL1) ? ctrl_ld
                       : (state_r == H_CTRL2) ? ctrl_rd
                       : (state_r == H_HI)    ? hi_w
                       : (state_r == H_LO)    ? lo_w
                       : (state_r == H_SUM)   ? sum_r
                       : `FCD_CTRL_ADDR;
  // byte sum of one padded coefficient
  wire [15:0] byte_add = 16'(coef_r[26:24]) + 16'(coef_r[23:16])
                         + 16'(coef_r[15:8]) + 16'(coef_r[7:0]);
  wire [31:0] gain_add = coef_r[26] ? (gain_r - 32'(coef_r[25:0]))
                                    : (gain_r + 32'(coef_r[25:0]));
  // half internal period per unused slot, two spare cycles
  wire [15:0] fill_cyc = 16'((`FCD_MAX_COEF - 32'(n_coef_r)) * `FCD_HALF_INTERNAL_DIVIDED_CLOCK + 2);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      state_r <= H_IDLE;
      cnt_r   <= 6'h00;
      wait_r  <= 16'h0000;
    end
    else
    begin
      case (state_r)
        H_IDLE:
          if (go_wr && code_ok)
            state_r <= H_ADDR1;
        H_ADDR1:
          state_r <= H_CTRL1;
        H_CTRL1:
        begin
          cnt_r   <= 6'h00;
          state_r <= H_WAITC;
        end
        // coefficients go out in the order software gives
        H_WAITC:
          if (coef_wr)
            state_r <= H_HI;
        H_HI:
          state_r <= H_LO;
        H_LO:
        begin
          cnt_r   <= cnt_r + 6'h01;
          state_r <= (cnt_r + 6'h01 == n_coef_r) ? H_SUM : H_WAITC;
        end
        // checksum right after the last lower word
        H_SUM:
        begin
          wait_r  <= fill_cyc;
          state_r <= H_FILL;
        end
        // hold off while the device zero-fills
        H_FILL:
          if (wait_r == 16'h0000)
            state_r <= H_ADDR2;
          else
            wait_r <= wait_r - 16'h0001;
        H_ADDR2:
          state_r <= H_CTRL2;
        H_CTRL2:
          state_r <= H_READ;
        H_READ:
          state_r <= H_RESP;
        H_RESP:
          if (bus.rd_valid)
            state_r <= H_IDLE;
        default:
          state_r <= H_IDLE;
      endcase
    end

  // settings latched at start
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      tap_r    <= 4'h0;
      dec_r    <= 3'h0;
      byp_r    <= 1'b0;
      n_coef_r <= 6'h00;
    end
    else if (go_wr)
    begin
      tap_r    <= pwdata[3:0];
      dec_r    <= pwdata[6:4];
      byp_r    <= pwdata[7];
      n_coef_r <= n_req;
    end

  // coefficient, checksum and gain accumulation
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      coef_r <= 27'h0000000;
      sum_r  <= 16'h0000;
      gain_r <= 32'h00000000;
    end
    else if (go_wr)
    begin
      sum_r  <= 16'h0000;
      gain_r <= 32'h00000000;
    end
    else if (coef_wr)
      coef_r <= pwdata[26:0];
    else if (state_r == H_HI)
    begin
      sum_r  <= sum_r + byte_add;
      gain_r <= gain_add;
    end

  // check bit 7 of the status word
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      verified_r <= 1'b0;
      gain_err_r <= 1'b0;
    end
    else if (go_wr)
      verified_r <= 1'b0;
    else if (resp)
    begin
      verified_r <= bus.rd_data[`FCD_STAT_OK_BIT];
      gain_err_r <= !sum_ok;
    end

  // ----------------------------------------
  // interrupts: done, failed, refused start
  // ----------------------------------------
  wire [`FCD_IRQ_W-1:0] ev = {go_wr && !code_ok,
                              resp && !bus.rd_data[`FCD_STAT_OK_BIT],
                              resp};
  // read clears only what it reported, a new event wins
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_rd ? irq_stat_r & ~prdata_r[`FCD_IRQ_W-1:0] : irq_stat_r) | ev;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      irq_mask_r <= '0;
    else if (done && pwrite && sel_mask)
      irq_mask_r <= pwdata[`FCD_IRQ_W-1:0];

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      prdata_r <= 32'h00000000;
    else if (psel && !penable)
      prdata_r <= rd_mux;

  // device port outputs, one cycle after the state
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      wr_r <= 1'b0;
      wd_r <= 16'h0000;
      rd_r <= 1'b0;
    end
    else
    begin
      wr_r <= send;
      rd_r <= state_r == H_READ;
      if (send)
        wd_r <= word_sel;
    end

  assign prdata        = prdata_r;
  assign irq           = |(irq_stat_r & irq_mask_r);
  assign bus.wr_strobe = wr_r;
  assign bus.wr_data   = wd_r;
  assign bus.rd_strobe = rd_r;
endmodule // fcd_host

// ---- pkg/fcd_map.svh ----
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
// ----------------------------------------
// device register port
// ----------------------------------------
`define FCD_CTRL_ADDR      16'h0001
`define FCD_CTRL_LOAD_BIT  15
`define FCD_CTRL_RDST_BIT  11
`define FCD_CTRL_TAP_LSB   5
`define FCD_CTRL_BYP_BIT   4
`define FCD_CTRL_RESET     16'h001a
`define FCD_STAT_OK_BIT    7
`define FCD_MAX_COEF       48
`define FCD_TAP_STEP       6
`define FCD_UNITY_SUM      32'h03ffffff
// ----------------------------------------
// timing: clk period and internal clock divide
// ----------------------------------------
`define FCD_CLK_NS         8
`define FCD_INTERNAL_DIVIDED_CLOCK_DIV       2
`define FCD_HALF_INTERNAL_DIVIDED_CLOCK      (`FCD_INTERNAL_DIVIDED_CLOCK_DIV / 2)
// ----------------------------------------
// host apb register offsets
// ----------------------------------------
`define FCD_REG_CTRL       8'h00
`define FCD_REG_COEF       8'h04
`define FCD_REG_STAT       8'h08
`define FCD_REG_IRQ        8'h0c
`define FCD_REG_MASK       8'h10
`define FCD_GO_BIT         31
`define FCD_IRQ_W          3
`endif

// ---- pkg/fcd_pkg.sv ----
package fcd_pkg;
  typedef enum logic [1:0]
  {
    DEV_IDLE = 2'b00,
    DEV_LOAD = 2'b01,
    DEV_FILL = 2'b10
  } fcd_dev_state_type;

  typedef enum logic [3:0]
  {
    H_IDLE  = 4'b0000,
    H_ADDR1 = 4'b0001,
    H_CTRL1 = 4'b0010,
    H_WAITC = 4'b0011,
    H_HI    = 4'b0100,
    H_LO    = 4'b0101,
    H_SUM   = 4'b0110,
    H_FILL  = 4'b0111,
    H_ADDR2 = 4'b1000,
    H_CTRL2 = 4'b1001,
    H_READ  = 4'b1010,
    H_RESP  = 4'b1011
  } fcd_host_state_type;
endpackage

// ---- pkg/fcd_bus_if.sv ----
interface fcd_bus_if;
  logic        wr_strobe;  // one-cycle write of wr_data
  logic [15:0] wr_data;
  logic        rd_strobe;  // one-cycle read request
  logic        rd_valid;   // one-cycle read answer
  logic [15:0] rd_data;

  modport device (input wr_strobe, input wr_data, input rd_strobe,
                  output rd_valid, output rd_data);
  modport host   (output wr_strobe, output wr_data, output rd_strobe,
                  input rd_valid, input rd_data);
endinterface

// ---- hdl/fcd_device.sv ----
`include "fcd_map.svh"
module fcd_device
  import fcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  fcd_bus_if.device        bus,
  input  wire logic [15:0] sample_word,
  input  wire logic [5:0]  coef_idx,
  output logic      [26:0] coef_word,
  output logic      [15:0] control_word,
  output logic             download_verified_flag,
  output logic             fill_busy
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  fcd_dev_state_type state_r;
  logic        addr_phase_r;   // high: next write is an address
  logic [15:0] reg_addr_r;
  logic [15:0] ctrl_r;
  logic        rdst_pend_r;
  logic        ok_r;
  logic [6:0]  word_cnt_r;
  logic [10:0] hi_r;
  logic [15:0] sum_r;
  logic [5:0]  fill_idx_r;
  logic [5:0]  n_coef_r;
  logic        half_tick;
  logic [26:0] mem_r [`FCD_MAX_COEF];
  logic [15:0] rd_data_r;
  logic        rd_valid_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire        wr       = bus.wr_strobe;
  wire [15:0] wd       = bus.wr_data;
  wire [3:0]  tap_code = wd[`FCD_CTRL_TAP_LSB+3:`FCD_CTRL_TAP_LSB];
  wire [5:0]  n_req    = 6'((tap_code[3:1] + 4'h1) * `FCD_TAP_STEP);
  wire ctrl_wr  = wr && !addr_phase_r && state_r == DEV_IDLE
                  && reg_addr_r == `FCD_CTRL_ADDR;
  wire start_ld = ctrl_wr && wd[`FCD_CTRL_LOAD_BIT] && tap_code[0];
  wire ld_wr    = wr && state_r == DEV_LOAD;
  wire last_w   = word_cnt_r == {n_coef_r, 1'b0};
  wire coef_wr  = ld_wr && !last_w && word_cnt_r[0];
  wire sum_wr   = ld_wr && last_w;
  wire fill_wr  = state_r == DEV_FILL && half_tick;
  wire        mem_we   = coef_wr || fill_wr;
  wire [5:0]  mem_addr = fill_wr ? fill_idx_r : word_cnt_r[6:1];
  // sign and 26 magnitude bits, padding dropped
  wire [26:0] mem_din  = fill_wr ? 27'h0000000 : {hi_r, wd};
  // byte sum of the coefficient word pair
  wire [15:0] byte_add = 16'(hi_r[10:8]) + 16'(hi_r[7:0]) + 16'(wd[15:8])
                         + 16'(wd[7:0]);
  wire [15:0] status_w = {8'h00, ok_r, 2'b00, ctrl_r[`FCD_CTRL_BYP_BIT], 1'b1,
                          ctrl_r[2:0]};

  // ----------------------------------------
  // half internal clock divider
  // ----------------------------------------
  localparam int HALF = (`FCD_HALF_INTERNAL_DIVIDED_CLOCK < 1) ? 1 : `FCD_HALF_INTERNAL_DIVIDED_CLOCK;
  logic [7:0] div_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      div_r <= 8'h00;
    else
      div_r <= (half_tick) ? 8'h00 : div_r + 8'h01;
  assign half_tick = div_r == 8'(HALF - 1);

  // ----------------------------------------
  // address/data phase and control
  // ----------------------------------------
  // address word then one data word
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      addr_phase_r <= 1'b1;
    else if (wr && state_r == DEV_IDLE)
      addr_phase_r <= !addr_phase_r;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      reg_addr_r <= 16'h0000;
    else if (wr && addr_phase_r && state_r == DEV_IDLE)
      reg_addr_r <= wd;

  // self-clearing upper bits are not kept
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      ctrl_r <= `FCD_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_r <= {7'h00, wd[8:0]};

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      rdst_pend_r <= 1'b0;
    else if (ctrl_wr && wd[`FCD_CTRL_RDST_BIT])
      rdst_pend_r <= 1'b1;
    else if (bus.rd_strobe)
      rdst_pend_r <= 1'b0;

  // ----------------------------------------
  // download sequencer
  // ----------------------------------------
  // writes are coefficient data until checksum
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      state_r    <= DEV_IDLE;
      word_cnt_r <= 7'h00;
      n_coef_r   <= 6'h00;
      fill_idx_r <= 6'h00;
    end
    else
    begin
      case (state_r)
        DEV_IDLE:
          if (start_ld)
          begin
            state_r    <= DEV_LOAD;
            word_cnt_r <= 7'h00;
            n_coef_r   <= n_req;
          end
        DEV_LOAD:
          if (sum_wr)
          begin
            fill_idx_r <= n_coef_r;
            state_r    <= (n_coef_r == 6'(`FCD_MAX_COEF)) ? DEV_IDLE : DEV_FILL;
          end
          else if (ld_wr)
            word_cnt_r <= word_cnt_r + 7'h01;
        // zero one unused slot per half period
        DEV_FILL:
          if (half_tick)
          begin
            fill_idx_r <= fill_idx_r + 6'h01;
            if (fill_idx_r == 6'(`FCD_MAX_COEF - 1))
              state_r <= DEV_IDLE;
          end
        default:
          state_r <= DEV_IDLE;
      endcase
    end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      hi_r <= 11'h000;
    else if (ld_wr && !last_w && !word_cnt_r[0])
      hi_r <= wd[10:0];

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      sum_r <= 16'h0000;
    else if (start_ld)
      sum_r <= 16'h0000;
    else if (coef_wr)
      sum_r <= sum_r + byte_add;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      ok_r <= 1'b0;
    else if (start_ld)
      ok_r <= 1'b0;
    else if (sum_wr)
      ok_r <= sum_r == wd;

  // ----------------------------------------
  // coefficient store, one entry per slot
  // ----------------------------------------
  for (genvar i = 0; i < `FCD_MAX_COEF; i++)
  begin : g_slot
    always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
        mem_r[i] <= 27'h0000000;
      else if (mem_we && mem_addr == 6'(i))
        mem_r[i] <= mem_din;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= bus.rd_strobe;
      if (bus.rd_strobe)
        rd_data_r <= rdst_pend_r ? status_w : sample_word;
    end

  assign bus.rd_valid           = rd_valid_r;
  assign bus.rd_data            = rd_data_r;
  assign coef_word              = mem_r[(coef_idx < 6'(`FCD_MAX_COEF)) ? coef_idx : 6'h00];
  assign control_word           = ctrl_r;
  assign download_verified_flag = ok_r;
  assign fill_busy              = state_r != DEV_IDLE;
endmodule // fcd_device

// ---- tb/fcd_bus_monitor.sv ----
// ----------------------------------------
// device port checker
// ----------------------------------------
module fcd_bus_monitor
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wr_strobe,
  input wire logic [15:0] wr_data,
  input wire logic        rd_strobe,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        phase_r, load_r, up_r, pend_r, srd_r, ok_r;
  logic [6:0]  left_r;
  logic [5:0]  gap_r, n_r;
  logic [15:0] sum_r;
  // byte sum of a word and the tap count of a control word
  wire  [15:0] bsum  = 16'(wr_data[15:8]) + 16'(wr_data[7:0]);
  wire  [5:0]  n_dec = 6'(6 * (32'(wr_data[8:6]) + 1));
  wire         ctl_w = wr_strobe && !load_r && phase_r;
  // track address/data phase, load words, checksum and fill wait
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      {phase_r, load_r, up_r, pend_r, srd_r, ok_r} <= 6'h00;
      {left_r, gap_r, n_r, sum_r} <= 35'h0;
    end
    else
    begin
      if (gap_r != 6'h00) gap_r <= gap_r - 6'h01;
      srd_r <= rd_strobe && pend_r;
      if (rd_strobe) pend_r <= 1'b0;
      if (wr_strobe && load_r)
      begin
        left_r <= left_r - 7'h01;
        up_r   <= !up_r;
        sum_r  <= sum_r + bsum;
        if (left_r == 7'h01)
        begin
          load_r <= 1'b0;
          ok_r   <= (wr_data == sum_r);
          gap_r  <= 6'd48 - n_r;
        end
      end
      else if (wr_strobe)
      begin
        phase_r <= !phase_r;
        if (ctl_w && wr_data[15] && wr_data[5])
        begin
          {load_r, up_r, sum_r, n_r} <= {2'b11, 16'h0, n_dec};
          left_r <= {n_dec, 1'b1};
        end
        if (ctl_w && wr_data[11]) pend_r <= 1'b1;
      end
    end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  rd_answer_a:
    assert property (rd_strobe |=> rd_valid) else $error("read answer missing");
  rd_cause_a:
    assert property (rd_valid |-> $past(rd_strobe)) else $error("read answer unasked");
  rd_hold_a:
    assert property (!rd_valid |-> $stable(rd_data)) else $error("read data moved");
  addr_first_a:
    assert property (wr_strobe && !load_r && !phase_r |-> wr_data == 16'h0001)
      else $error("address word wrong");
  ctrl_form_a:
    assert property (ctl_w |-> wr_data[3] && !wr_data[10] && (!wr_data[15] || wr_data[5]))
      else $error("control word malformed");
  upper_pad_a:
    assert property (wr_strobe && load_r && up_r && left_r != 7'h01 |-> wr_data[15:11] == 5'h00)
      else $error("upper word not padded");
  checksum_eq_a:
    assert property (wr_strobe && load_r && left_r == 7'h01 |-> wr_data == sum_r)
      else $error("checksum wrong");
  fill_wait_a:
    assert property (wr_strobe |-> gap_r == 6'h00) else $error("write during fill");
  status_flag_a:
    assert property (rd_valid && srd_r |-> rd_data[7] == ok_r && rd_data[3])
      else $error("status flag wrong");
  status_sel_a:
    assert property (rd_strobe |-> pend_r) else $error("read without status select");
  cover property (wr_strobe && load_r && left_r == 7'h01);
  cover property (rd_valid && srd_r);
  cover property (gap_r == 6'h01);
endmodule // fcd_bus_monitor

// ---- tb/fir_coefficient_download_tb_top.sv ----
`include "fcd_map.svh"
module fir_coefficient_download_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, irq, errv, ia;
  logic [15:0] smp = 16'h0, smp2 = 16'h0, ctl, ctl2;
  logic [5:0]  cidx = 6'h00, cidx2 = 6'h00;
  logic [26:0] cw, cw2;
  logic        ok1, ok2, fb1, fb2;
  int          error_cnt = 0, n_compared = 0, seed = 93078, cycles = 0;
  logic [15:0] exp_q[$];
  logic [26:0] ex[12] = '{27'h32b9688, 27'h1bf183c, 27'h0156626, 27'h4a81e6a, 27'h45f2a96,
    27'h02c49c2, 27'h050e9f6, 27'h010dbd8, 27'h42fde54, 27'h437445a, 27'h41b7d6e, 27'h4043b5f};
  fcd_bus_if bus ();
  fcd_bus_if bus2 ();
  fcd_host u_fcd_host (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus(bus));
  fcd_device u_fcd_device (.clk(clk), .reset_n(reset_n), .bus(bus), .sample_word(smp),
    .coef_idx(cidx), .coef_word(cw), .control_word(ctl), .download_verified_flag(ok1),
    .fill_busy(fb1));
  fcd_device u_fcd_device_2 (.clk(clk), .reset_n(reset_n), .bus(bus2), .sample_word(smp2),
    .coef_idx(cidx2), .coef_word(cw2), .control_word(ctl2), .download_verified_flag(ok2),
    .fill_busy(fb2));
  fcd_bus_monitor u_fcd_bus_monitor (.clk(clk), .reset_n(reset_n), .wr_strobe(bus.wr_strobe),
    .wr_data(bus.wr_data), .rd_strobe(bus.rd_strobe), .rd_valid(bus.rd_valid),
    .rd_data(bus.rd_data));
  // clock, timeout and wire word watcher
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  always @(posedge clk)
    if (bus.wr_strobe === 1'b1)
      check(bus.wr_data, (exp_q.size() != 0) ? {16'h0, exp_q.pop_front()} : 32'h10000);
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb master: setup, access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // full download through the host, words noted for the watcher
  task automatic run_load(input logic [3:0] code, input bit exm);
    logic [26:0] c;
    logic [15:0] sum;
    logic [3:0]  bd;
    int          n, gs;
    n = 6 * (code[3:1] + 1);
    sum = 16'h0;
    gs = 0;
    bd = exm ? 4'h9 : {1'($random(seed)), 3'({$random(seed)} % 6)};
    exp_q.push_back(16'h0001);
    exp_q.push_back(exm ? 16'h8079 : {7'h40, code, bd[3], 1'b1, bd[2:0]});
    apb(1'b1, `FCD_REG_CTRL, {1'b1, 23'h0, bd, code});
    for (int i = 0; i < n; i++)
    begin
      c = exm ? ex[i] : 27'($random(seed));
      exp_q.push_back({5'h00, c[26:16]});
      exp_q.push_back(c[15:0]);
      sum += 16'(c[26:24]) + 16'(c[23:16]) + 16'(c[15:8]) + 16'(c[7:0]);
      gs += c[26] ? -int'(c[25:0]) : int'(c[25:0]);
      apb(1'b1, `FCD_REG_COEF, {5'h00, c});
    end
    exp_q.push_back(exm ? 16'h0e6b : sum);
    exp_q.push_back(16'h0001);
    exp_q.push_back(exm ? 16'h0879 : {7'h04, code, bd[3], 1'b1, bd[2:0]});
    rdv = 32'h0;
    while (rdv[0] !== 1'b1 || rdv[1] !== 1'b0) apb(1'b0, `FCD_REG_STAT, 32'h0);
    check(rdv[5:4], {gs != 67108863, 1'b1});
    check(exp_q.size(), 0);
  endtask
  // direct device driver, optionally with a wrong checksum
  task automatic dwr(input logic [15:0] w);
    @(posedge clk);
    {bus2.wr_strobe, bus2.wr_data} <= {1'b1, w};
    @(posedge clk);
    bus2.wr_strobe <= 1'b0;
  endtask
  task automatic drd();
    @(posedge clk);
    bus2.rd_strobe <= 1'b1;
    @(posedge clk);
    bus2.rd_strobe <= 1'b0;
    @(posedge clk);
    check(bus2.rd_valid, 1);
  endtask
  task automatic dev_load(input bit bad);
    logic [15:0] sum;
    logic [26:0] c;
    int          n;
    sum = 16'h0;
    dwr(16'h0001);
    dwr(16'h8029);
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 2) ? 27'h0000001 : 27'($random(seed));
      sum += 16'(c[26:24]) + 16'(c[23:16]) + 16'(c[15:8]) + 16'(c[7:0]);
      dwr({5'h1f, c[26:16]});
      dwr(c[15:0]);
    end
    dwr(bad ? sum ^ 16'h0100 : sum);
    n = 0;
    while (fb2 === 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check(n >= 41 && n <= 43, 1);
    check(ok2, !bad);
    dwr(16'h0001);
    dwr(16'h0829);
    drd();
    check(bus2.rd_data[7], !bad);
    check(ctl2, 16'h0029);
    smp2 <= 16'($random(seed));
    drd();
    check(bus2.rd_data, smp2);
    cidx2 <= 6'd2;
    @(posedge clk);
    check(cw2, 27'h0000001);
    cidx2 <= 6'd6;
    @(posedge clk);
    @(posedge clk);
    check(cw2, 27'h0);
  endtask
  // main sequence
  initial
  begin
    {bus2.wr_strobe, bus2.rd_strobe, bus2.wr_data} = 18'h0;
    smp = 16'($random(seed));
    repeat (20) @(posedge clk);
    check(ctl, 16'h001a);
    reset_n <= 1'b1;
    apb(1'b0, `FCD_REG_STAT, 32'h0);
    check({rdv[5:4], rdv[2:1]}, 0);
    apb(1'b0, 8'h14, 32'h0);
    check(errv, 1);
    apb(1'b1, `FCD_REG_COEF, 32'h0);
    check(errv, 1);
    run_load(4'h3, 1'b1);
    check(ok1, 1);
    check(ctl, 16'h0079);
    check(fb1, 0);
    foreach (ex[i])
    begin
      cidx <= 6'(i);
      @(posedge clk);
      @(posedge clk);
      check(cw, ex[i]);
    end
    cidx <= 6'd12;
    @(posedge clk);
    @(posedge clk);
    check(cw, 27'h0);
    apb(1'b1, `FCD_REG_MASK, 32'h0);
    @(posedge clk);
    ia = irq;
    apb(1'b1, `FCD_REG_MASK, 32'h7);
    @(posedge clk);
    check(ia ^ irq, 1);
    apb(1'b0, `FCD_REG_IRQ, 32'h0);
    check(rdv[2:0], 3'b001);
    apb(1'b0, `FCD_REG_IRQ, 32'h0);
    check(rdv[2:0], 3'b000);
    check(irq, 0);
    apb(1'b1, `FCD_REG_CTRL, 32'h8000_0092);
    repeat (4) @(posedge clk);
    apb(1'b0, `FCD_REG_IRQ, 32'h0);
    check(rdv[2], 1);
    for (int k = 1; k < 16; k += 2) run_load(4'(k), 1'b0);
    run_load(4'h3, 1'b1);
    cidx <= 6'd47;
    @(posedge clk);
    @(posedge clk);
    check(cw, 27'h0);
    dev_load(1'b1);
    dev_load(1'b0);
    give_verdict();
  end
endmodule // fir_coefficient_download_tb_top
